/* pkg/fcct_regs.svh */
// Field positions, reset values and timing counts of the counter/timer
// Overview of operation
// - Control bit 6 high counts trigger edges, low times from the clock.
// - Counting mode decrements on the clock after each active trigger edge.
// - Control bit 4 picks rising (1) or falling (0) trigger edges.
// - Channels 0 to 2 pulse their zero-count output high at zero.
// - At zero the counter reloads the time constant without a gap.
// - A new time constant during counting waits for the present zero.
// - Timing mode prescales the clock by 256 (bit 5 high) or 16.
// - Time constants 1 to 256 are accepted and reloaded each zero.
// - Timing mode zero pulses repeat every clock times prescale times constant.
// - With bit 3 low the timer starts itself after the constant write.
// - With bit 3 high a trigger edge starts prescaling two clocks later.
// - Control write without constant restarts an idle timer, after the next trigger if bit 3 is high.
// - A trigger too close to the clock edge delays start one cycle.
// - Bit 7 raises a request per zero count, never for earlier zeros.
// - A channel write with bit 0 high is stored as control word.
// - Two select inputs address one channel; writes reach that channel only.
// - Control bit 2 makes the next write to that channel the constant.
// - Control bit 1 high resets the channel; low lets it continue.
// - One stored vector serves all four channels.
// - A time constant of zero counts as 256.
// - Soft reset stops counting and stores its control word; a following constant restarts.
// - Channel 0 write with bit 0 low stores the vector; bits 2:1 name channel.
// - Hardware reset stops all channels and clears interrupt enables.
`ifndef FCCT_REGS_SVH
`define FCCT_REGS_SVH

`define FCCT_BIT_INT_EN 7
`define FCCT_BIT_MODE 6
`define FCCT_BIT_PRESC 5
`define FCCT_BIT_EDGE 4
`define FCCT_BIT_TRIG 3
`define FCCT_BIT_TC_NEXT 2
`define FCCT_BIT_SRESET 1
`define FCCT_BIT_CTRL 0

`define FCCT_CTRL_RESET 8'h00
`define FCCT_VEC_RESET 8'h00
`define FCCT_MASK_P16 8'h0F
`define FCCT_MASK_P256 8'hFF

// Clocks from time constant write to first prescaler clock
`define FCCT_AUTO_START_CYC 3'h1
// Clocks from trigger edge to first prescaler clock
`define FCCT_TRIG_START_CYC 3'h2

`endif

/* pkg/fcct_pkg.sv */
// Types shared by the counter/timer design
package fcct_pkg;
    typedef enum logic [2:0] {
        FCCT_IDLE,
        FCCT_WAIT_TRIG,
        FCCT_START,
        FCCT_RUN
    } fcct_state_t;
endpackage

/* rtl/fcct_core.sv */
// Four-channel counter/timer with CPU write/read port
`timescale 1ns/1ps
`include "fcct_regs.svh"

module fcct_core
    import fcct_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic chip_enable_n,
    input wire logic io_request_n,
    input wire logic read_n,
    input wire logic machine_cycle_one_n,
    input wire logic channel_sel_lo,
    input wire logic channel_sel_hi,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    input wire logic [3:0] ext_count_trigger_in,
    output logic [2:0] zero_count_pulse_out,
    output logic [3:0] int_request,
    output logic [7:0] int_vector
);

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic access_prev;
    logic read_prev;
    logic [7:0] vector_base;
    logic [3:0] tc_next;
    logic [7:0] count [4];
    logic [3:0] zero_hit;

    wire [1:0] sel = {channel_sel_hi, channel_sel_lo};
    wire io_cycle = !chip_enable_n && !io_request_n && machine_cycle_one_n;
    wire wr_active = io_cycle && read_n;
    wire rd_active = io_cycle && !read_n;
    // One write per bus cycle: only the first clock of the strobe counts
    wire wr_take = wr_active && !access_prev;
    wire [3:0] wr_chan = wr_take ? (4'h1 << sel) : 4'h0;
    wire sel_tc = tc_next[sel];
    wire wr_ctrl = wr_take && !sel_tc && data_in[`FCCT_BIT_CTRL];
    // vector goes to channel 0 only
    wire wr_vec = wr_take && !sel_tc && !data_in[`FCCT_BIT_CTRL]
                  && (sel == 2'h0);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            access_prev <= 1'b0;
        end else begin
            access_prev <= wr_active;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            read_prev <= 1'b0;
        end else begin
            read_prev <= rd_active;
        end
    end

    // ------------------------------------------------------------
    // Read path and vector
    // ------------------------------------------------------------
    // snapshot at the start of the read, counting is untouched
    wire [7:0] next_data_out = (rd_active && !read_prev) ? count[sel]
                                                         : data_out;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            data_out <= 8'h00;
        end else begin
            data_out <= next_data_out;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            data_oe <= 1'b0;
        end else begin
            data_oe <= rd_active;
        end
    end

    // a single vector serves all channels
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            vector_base <= `FCCT_VEC_RESET;
        end else if (wr_vec) begin
            vector_base <= data_in;
        end
    end

    // ------------------------------------------------------------
    // Interrupt request and channel vector
    // ------------------------------------------------------------
    logic [3:0] irq_now;
    logic [1:0] irq_chan;

    always_comb begin
        irq_chan = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            if (irq_now[i]) begin
                irq_chan = 2'(i);
            end
        end
    end

    // channel number fills bits 2:1, bit 0 stays low
    wire [7:0] next_int_vector = (|irq_now)
        ? {vector_base[7:3], irq_chan, 1'b0} : int_vector;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            int_request <= 4'h0;
        end else begin
            int_request <= irq_now;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            int_vector <= 8'h00;
        end else begin
            int_vector <= next_int_vector;
        end
    end

    // channel 3 has no zero-count output
    assign zero_count_pulse_out = zero_hit[2:0];

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    for (genvar g = 0; g < 4; g++) begin : g_chan
        logic [7:0] ctrl;
        logic [7:0] tconst;
        logic tc_valid;
        logic [7:0] presc;
        logic [2:0] start_cnt;
        logic trig_prev;
        fcct_state_t state;
        fcct_state_t next_state;
        logic [2:0] next_start_cnt;

        // --------------------------------------------------------
        // Write decode and trigger
        // --------------------------------------------------------
        wire wr_here = wr_chan[g];
        wire ctrl_w = wr_here && !tc_next[g] && data_in[`FCCT_BIT_CTRL];
        wire tc_w = wr_here && tc_next[g];
        wire sreset = ctrl_w && data_in[`FCCT_BIT_SRESET];
        // Mode and edge follow a control word being written this cycle
        wire [7:0] ctrl_eff = ctrl_w ? data_in : ctrl;
        wire counting = ctrl_eff[`FCCT_BIT_MODE];
        wire trig = ext_count_trigger_in[g];
        wire edge_hit = ctrl_eff[`FCCT_BIT_EDGE] ? (trig && !trig_prev)
                                                 : (!trig && trig_prev);
        wire [7:0] presc_mask = ctrl[`FCCT_BIT_PRESC] ? `FCCT_MASK_P256
                                                      : `FCCT_MASK_P16;
        wire presc_tick = (presc & presc_mask) == presc_mask;
        // a constant write in the same clock must not swallow a count
        wire dec = (state == FCCT_RUN) && !sreset
                   && (ctrl[`FCCT_BIT_MODE] ? edge_hit : presc_tick);
        // a loaded zero decrements to 255, so it spans 256 counts
        wire at_zero = dec && (count[g] == 8'h01);
        // only zeros reached while enabled raise a request
        assign irq_now[g] = at_zero && ctrl[`FCCT_BIT_INT_EN];

        // --------------------------------------------------------
        // Start sequencer
        // --------------------------------------------------------
        always_comb begin
            next_state = state;
            next_start_cnt = start_cnt;
            if (sreset) begin
                // stop, restart comes with the next constant or a control-only write once a constant is held
                next_state = FCCT_IDLE;
            end else if (tc_w) begin
                if (state != FCCT_RUN) begin
                    if (ctrl[`FCCT_BIT_MODE]) begin
                        next_state = FCCT_RUN;
                    end else if (ctrl[`FCCT_BIT_TRIG]) begin
                        // wait for the trigger after this write
                        next_state = FCCT_WAIT_TRIG;
                    end else begin
                        // automatic start after the write cycle
                        next_state = FCCT_START;
                        next_start_cnt = `FCCT_AUTO_START_CYC;
                    end
                end
            end else if (ctrl_w && !data_in[`FCCT_BIT_TC_NEXT] && tc_valid
                         && state == FCCT_IDLE) begin
                // control-only write re-arms a configured channel
                if (data_in[`FCCT_BIT_MODE]) begin
                    next_state = FCCT_RUN;
                end else if (data_in[`FCCT_BIT_TRIG]) begin
                    next_state = FCCT_WAIT_TRIG;
                end else begin
                    next_state = FCCT_START;
                    next_start_cnt = `FCCT_AUTO_START_CYC;
                end
            end else begin
                unique case (state)
                    FCCT_IDLE: begin
                        next_state = FCCT_IDLE;
                    end
                    FCCT_WAIT_TRIG: begin
                        // trigger starts prescaling two clocks on
                        if (edge_hit) begin
                            next_state = FCCT_START;
                            next_start_cnt = `FCCT_TRIG_START_CYC - 3'h1;
                        end
                    end
                    FCCT_START: begin
                        if (start_cnt <= 3'h1) begin
                            next_state = FCCT_RUN;
                        end
                        next_start_cnt = start_cnt - 3'h1;
                    end
                    FCCT_RUN: begin
                        next_state = FCCT_RUN;
                    end
                    default: begin
                        next_state = FCCT_IDLE;
                    end
                endcase
            end
        end

        // --------------------------------------------------------
        // Channel registers
        // --------------------------------------------------------
        // control store, reset clears enables
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                ctrl <= `FCCT_CTRL_RESET;
            end else if (ctrl_w) begin
                // reset request is not a stored condition
                ctrl <= data_in & ~(8'h01 << `FCCT_BIT_SRESET);
            end
        end

        // next write after bit 2 is the constant
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                tc_next[g] <= 1'b0;
            end else if (ctrl_w) begin
                tc_next[g] <= data_in[`FCCT_BIT_TC_NEXT];
            end else if (tc_w) begin
                tc_next[g] <= 1'b0;
            end
        end

        // while running, the constant only reaches the counter at a zero
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                tconst <= 8'h00;
            end else if (tc_w) begin
                tconst <= data_in;
            end
        end

        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                tc_valid <= 1'b0;
            end else if (tc_w) begin
                tc_valid <= 1'b1;
            end
        end

        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                state <= FCCT_IDLE;
                start_cnt <= 3'h0;
            end else begin
                state <= next_state;
                start_cnt <= next_start_cnt;
            end
        end

        // Edge history runs in every state, so arming never sees a
        // stale level as a fresh edge
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                trig_prev <= 1'b0;
            end else begin
                trig_prev <= trig;
            end
        end

        // --------------------------------------------------------
        // Prescaler and down-counter
        // --------------------------------------------------------
        // Prescaler is cleared until the timer runs, so the first
        // period after a start is whole
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                presc <= 8'h00;
            end else if (state != FCCT_RUN || counting) begin
                presc <= 8'h00;
            end else begin
                presc <= presc + 8'h01;
            end
        end

        // reload at zero, any constant 1 to 256, period
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                count[g] <= 8'h00;
            end else if (state != FCCT_RUN && next_state == FCCT_RUN) begin
                count[g] <= tc_w ? data_in : tconst;
            end else if (state == FCCT_START && tc_w) begin
                count[g] <= data_in;
            end else if (state != FCCT_RUN && tc_w) begin
                count[g] <= data_in;
            end else if (at_zero) begin
                count[g] <= tc_w ? data_in : tconst;
            end else if (dec) begin
                count[g] <= count[g] - 8'h01;
            end
        end

        // --------------------------------------------------------
        // Zero-count output
        // --------------------------------------------------------
        // one-clock zero-count pulse
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                zero_hit[g] <= 1'b0;
            end else begin
                zero_hit[g] <= at_zero;
            end
        end
    end

endmodule // fcct_core

/* tb/fcct_core_chk.sv */
// Assertion checker for the counter/timer bus and event outputs
`timescale 1ns/1ps

module fcct_core_chk (
    input wire logic clock,
    input wire logic rst,
    input wire logic chip_enable_n,
    input wire logic io_request_n,
    input wire logic read_n,
    input wire logic machine_cycle_one_n,
    input wire logic channel_sel_lo,
    input wire logic channel_sel_hi,
    input wire logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    input wire logic [3:0] ext_count_trigger_in,
    input wire logic [2:0] zero_count_pulse_out,
    input wire logic [3:0] int_request,
    input wire logic [7:0] int_vector
);
    // --------
    // Checks
    // --------
    wire logic rd_act;
    wire logic [1:0] low_ch;
    assign rd_act = !chip_enable_n && !io_request_n && !read_n
        && machine_cycle_one_n;
    // Lowest channel names the vector when several zero together
    assign low_ch = int_request[0] ? 2'h0 : int_request[1] ? 2'h1 :
        int_request[2] ? 2'h2 : 2'h3;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_oe_after_read: assert property (rd_act |=> data_oe)
        else $error("read data not enabled");
    a_oe_drops: assert property (!rd_act |=> !data_oe)
        else $error("read data enabled without read");
    a_dout_holds: assert property (data_oe && $past(data_oe)
        |-> $stable(data_out)) else $error("read data moved");
    a_zc_single: assert property (
        (zero_count_pulse_out & $past(zero_count_pulse_out)) == 3'h0)
        else $error("zero pulse longer than a clock");
    a_irq_single: assert property (
        (int_request & $past(int_request)) == 4'h0)
        else $error("request longer than a clock");
    a_irq_with_zc: assert property (
        (int_request[2:0] & ~zero_count_pulse_out) == 3'h0)
        else $error("request without zero count");
    a_vec_chan_id: assert property (|int_request
        |-> int_vector[2:0] == {low_ch, 1'h0}) else $error("vector id");
    a_vec_holds: assert property (int_request == 4'h0
        |-> $stable(int_vector)) else $error("vector moved");
endmodule // fcct_core_chk

bind fcct_core fcct_core_chk u_chk (.clock(clock), .rst(rst),
    .chip_enable_n(chip_enable_n), .io_request_n(io_request_n),
    .read_n(read_n), .machine_cycle_one_n(machine_cycle_one_n),
    .channel_sel_lo(channel_sel_lo), .channel_sel_hi(channel_sel_hi),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .ext_count_trigger_in(ext_count_trigger_in),
    .zero_count_pulse_out(zero_count_pulse_out),
    .int_request(int_request), .int_vector(int_vector));

/* tb/fcct_cpu_model.sv */
// Processor model issuing channel writes and reads
`timescale 1ns/1ps

module fcct_cpu_model (
    input wire logic clock,
    input wire logic [7:0] data_out,
    output logic chip_enable_n,
    output logic io_request_n,
    output logic read_n,
    output logic machine_cycle_one_n,
    output logic channel_sel_lo,
    output logic channel_sel_hi,
    output logic [7:0] data_in
);
    initial begin
        {chip_enable_n, io_request_n, read_n} = 3'h7;
        machine_cycle_one_n = 1'h1;
        {channel_sel_hi, channel_sel_lo} = 2'h0;
        data_in = 8'h00;
    end
    // --------
    // Bus cycles
    // --------
    // channel number on selects
    task automatic go(input logic [1:0] ch, input logic rd,
            input logic [7:0] d);
        @(negedge clock);
        {channel_sel_hi, channel_sel_lo} = ch;
        data_in = d;
        read_n = !rd;
        {chip_enable_n, io_request_n} = 2'h0;
    endtask
    // Released lines flip so a stale value cannot pass; one idle clock
    task automatic stop();
        {chip_enable_n, io_request_n, read_n} = 3'h7;
        {channel_sel_hi, channel_sel_lo} = ~{channel_sel_hi, channel_sel_lo};
        data_in = ~data_in;
        @(negedge clock);
    endtask
    task automatic wr(input logic [1:0] ch, input logic [7:0] d);
        go(ch, 1'h0, d);
        @(negedge clock);
        stop();
    endtask
    task automatic rd(input logic [1:0] ch, output logic [7:0] d);
        go(ch, 1'h1, data_in);
        repeat (2) @(negedge clock);
        d = data_out;
        stop();
    endtask
    // Acknowledge cycle: a write with machine cycle one active
    task automatic ack(input logic [1:0] ch, input logic [7:0] d);
        machine_cycle_one_n = 1'h0;
        wr(ch, d);
        machine_cycle_one_n = 1'h1;
    endtask
endmodule // fcct_cpu_model

/* tb/test_four_channel_counter_timer.sv */
// Self-checking bench for the counter/timer channels
`timescale 1ns/1ps

module test_four_channel_counter_timer;
    logic clock = 1'h0;
    logic rst = 1'h1;
    logic [3:0] trig = 4'h0;
    logic chip_enable_n, io_request_n, read_n, machine_cycle_one_n;
    logic channel_sel_lo, channel_sel_hi, data_oe;
    logic [7:0] data_in, data_out, int_vector, rv;
    logic [2:0] zero_count_pulse_out;
    logic [3:0] int_request;
    int fail_count = 0;
    int total_checks = 0;
    int cyc = 0;
    int irq3 = 0;
    int n0;
    int zc_cnt[3] = '{0, 0, 0};
    int per[3] = '{0, 0, 0};
    int last[3] = '{0, 0, 0};
    logic [7:0] t_ctl[3] = '{8'h25, 8'h05, 8'h05};
    logic [7:0] t_tc[3] = '{8'h01, 8'h00, 8'h02};
    int t_per[3] = '{256, 4096, 32};
    always #2.5 clock = ~clock;
    fcct_core DUT (.clock(clock), .rst(rst), .chip_enable_n(chip_enable_n),
        .io_request_n(io_request_n), .read_n(read_n),
        .machine_cycle_one_n(machine_cycle_one_n),
        .channel_sel_lo(channel_sel_lo), .channel_sel_hi(channel_sel_hi),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .ext_count_trigger_in(trig),
        .zero_count_pulse_out(zero_count_pulse_out),
        .int_request(int_request), .int_vector(int_vector));
    fcct_cpu_model u_cpu (.clock(clock), .data_out(data_out),
        .chip_enable_n(chip_enable_n), .io_request_n(io_request_n),
        .read_n(read_n), .machine_cycle_one_n(machine_cycle_one_n),
        .channel_sel_lo(channel_sel_lo), .channel_sel_hi(channel_sel_hi),
        .data_in(data_in));
    // --------
    // Monitors and helpers
    // --------
    // Sampled mid-cycle, clear of the edge that launches the outputs
    always @(negedge clock) begin
        cyc <= cyc + 1;
        irq3 <= irq3 + (int_request[3] === 1'h1);
        for (int i = 0; i < 3; i++) begin
            if (zero_count_pulse_out[i] === 1'h1) begin
                zc_cnt[i] <= zc_cnt[i] + 1;
                per[i] <= cyc - last[i];
                last[i] <= cyc;
            end
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Each level held two clocks, the shortest legal trigger period
    task automatic pulse(input int ch, input int n);
        repeat (2 * n) begin
            @(negedge clock);
            trig[ch] = ~trig[ch];
            @(negedge clock);
        end
    endtask
    task automatic wait_zc(input int ch, input int n);
        int goal;
        goal = zc_cnt[ch] + n;
        for (int k = 0; k < 20000 && zc_cnt[ch] < goal; k++)
            @(negedge clock);
        check(zc_cnt[ch], goal);
    endtask
    initial begin
        repeat (5) @(posedge clock);
        @(negedge clock);
        rst = 1'h0;
        check({int_vector, int_request, zero_count_pulse_out, data_oe}, 0);
        u_cpu.wr(2'h1, 8'h55);
        u_cpu.wr(2'h1, 8'h03);
        u_cpu.rd(2'h1, rv);
        check(rv, 8'h03);
        pulse(1, 1);
        u_cpu.rd(2'h1, rv);
        check(rv, 8'h02);
        u_cpu.wr(2'h1, 8'h55);
        u_cpu.wr(2'h1, 8'h05);
        u_cpu.rd(2'h1, rv);
        check(rv, 8'h02);
        pulse(1, 2);
        check(zc_cnt[1], 1);
        u_cpu.rd(2'h1, rv);
        check(rv, 8'h05);
        u_cpu.wr(2'h0, 8'hA8);
        u_cpu.wr(2'h2, 8'h50);
        u_cpu.wr(2'h3, 8'h55);
        u_cpu.wr(2'h3, 8'h02);
        pulse(3, 2);
        u_cpu.wr(2'h3, 8'hD1);
        check(irq3, 0);
        pulse(3, 2);
        check(irq3, 1);
        check(int_vector, 8'hAE);
        u_cpu.rd(2'h1, rv);
        check(rv, 8'h05);
        u_cpu.ack(2'h1, 8'h03);
        pulse(1, 1);
        u_cpu.rd(2'h1, rv);
        check(rv, 8'h04);
        for (int i = 0; i < 3; i++) begin
            u_cpu.wr(2'h0, t_ctl[i]);
            u_cpu.wr(2'h0, t_tc[i]);
            wait_zc(0, 3);
            check(per[0], t_per[i]);
        end
        u_cpu.wr(2'h0, 8'h03);
        n0 = zc_cnt[0];
        repeat (100) @(negedge clock);
        check(zc_cnt[0], n0);
        u_cpu.wr(2'h0, 8'h07);
        u_cpu.wr(2'h0, 8'h02);
        wait_zc(0, 2);
        check(per[0], 32);
        u_cpu.wr(2'h2, 8'h1D);
        u_cpu.wr(2'h2, 8'h01);
        repeat (100) @(negedge clock);
        check(zc_cnt[2], 0);
        pulse(2, 1);
        wait_zc(2, 2);
        check(per[2], 16);
        u_cpu.wr(2'h2, 8'h1B);
        n0 = zc_cnt[2];
        u_cpu.wr(2'h2, 8'h19);
        repeat (50) @(negedge clock);
        check(zc_cnt[2], n0);
        pulse(2, 1);
        wait_zc(2, 2);
        check(per[2], 16);
        @(negedge clock);
        rst = 1'h1;
        repeat (2) @(negedge clock);
        rst = 1'h0;
        check({int_vector, int_request, zero_count_pulse_out, data_oe}, 0);
        pulse(3, 2);
        check(irq3, 1);
        u_cpu.rd(2'h3, rv);
        check(rv, 8'h00);
        wrap_up();
    end
    initial begin
        repeat (60000) @(posedge clock);
        fail_count++;
        $display("watchdog expired");
        wrap_up();
    end
endmodule // test_four_channel_counter_timer
